// >>> pkr_pkg.sv
package pkr_pkg;

    // ------------------------------------------------------------
    // command codes and lengths
    // ------------------------------------------------------------
    localparam logic [7:0] PKR_OPC_READ_PACKET_REPORT = 8'h1d;
    localparam logic [7:0] PKR_OPC_READ_LIVE_POWER    = 8'h1f;
    localparam logic [7:0] PKR_LEN_PACKET_REPORT      = 8'h05;
    localparam logic [7:0] PKR_LEN_LIVE_POWER         = 8'h01;
    localparam logic [2:0] PKR_REPORT_BYTES           = 3'h5;
    localparam logic [2:0] PKR_SPI_STATUS_BYTES       = 3'h2;
    localparam logic [7:0] PKR_FILL_BYTE              = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PKR_ST_ACK_WAIVED   = 5;
    localparam int PKR_ST_TX_FINISHED  = 0;
    localparam int PKR_ER_SYNC_MISS    = 6;
    localparam int PKR_ER_OVERSIZE     = 5;
    localparam int PKR_ER_CHECKSUM     = 4;
    localparam int PKR_ER_ABORTED      = 3;
    localparam int PKR_ER_HEADER_SEEN  = 2;
    localparam int PKR_ER_RX_FINISHED  = 1;
    localparam int PKR_ER_BUSY         = 0;
    localparam logic [2:0] PKR_SYNC_NONE = 3'h0;
    localparam logic [2:0] PKR_SYNC_1    = 3'h1;
    localparam logic [2:0] PKR_SYNC_2    = 3'h2;
    localparam logic [2:0] PKR_SYNC_3    = 3'h4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PKR_RST_BYTE = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PKR_PT_GFSK    = 2'h0,
        PKR_PT_BLE     = 2'h1,
        PKR_PT_CHIRP   = 2'h2,
        PKR_PT_RANGING = 2'h3
    } pkr_pkt_type_t;

    typedef enum logic [1:0] {
        PKR_S_IDLE   = 2'b00,
        PKR_S_OPCODE = 2'b01,
        PKR_S_ARGS   = 2'b11,
        PKR_S_REPLY  = 2'b10
    } pkr_state_t;

    // one-cycle pulses and levels from the packet engine
    typedef struct packed {
        logic       packet_start;
        logic       sync_seen;
        logic [2:0] sync_index;
        logic       header_seen;
        logic       reception_finished;
        logic       transmit_finished;
        logic       oversize_length;
        logic       checksum_fail;
        logic       aborted;
        logic       ack_field;
        logic       snr_valid;
        logic [7:0] snr;
        logic       symbol_tick;
        logic       busy;
    } pkr_engine_t;

    // packet configuration levels
    typedef struct packed {
        pkr_pkt_type_t pkt_type;
        logic          dynamic_length;
        logic          checksum_enable;
        logic          sync_detect_enable;
    } pkr_config_t;

endpackage : pkr_pkg

// >>> pkr_packet_status_readout.sv
`timescale 1ns/1ps
// Notes on behaviour
// - spi report: two status, five bytes lsb first
// - uart report: length five, five bytes only
// - chirp and ranging give two meaningful bytes
// - byte layout depends on packet type
// - snr byte only in chirp and ranging
// - sync power latched at sync detection
// - snr is two's complement quarter dB
// - status byte: ack waived bit5, tx done bit0
// - error bit6 reports sync detection miss
// - error bit5 flags oversize dynamic length
// - error bit4 flags checksum fail
// - error bit3 flags abort, rx or tx
// - error bit2 set once header received, only with dynamic length
// - error bit1 set when reception completes
// - error bit0 follows engine busy
// - sync byte carries matched sync index
// - spi live power: status, status, power
// - live power any type; chirp per symbol
// - live power is minus twice dBm
// - uart live power: length one, one byte
module pkr_packet_status_readout (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 link_is_uart,
    input  wire logic                 frame_start,
    input  wire logic                 rx_valid,
    input  wire logic [7:0]           rx_byte,
    output logic                      tx_valid,
    input  wire logic                 tx_ready,
    output logic [7:0]                tx_byte,
    input  wire logic [7:0]           chip_status,
    input  wire logic [7:0]           power_level,
    input  wire pkr_pkg::pkr_engine_t engine,
    input  wire pkr_pkg::pkr_config_t config_in
);
    import pkr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        pkr_state_t st;
        logic [7:0] opcode;
        logic [2:0] idx;
        logic [2:0] left;
        logic [39:0] snap;
        logic [7:0] live_power_level;
        logic [7:0] sync_power_level;
        logic [7:0] snr;
        logic       sync_miss_flag;
        logic       oversize_length_flag;
        logic       checksum_fail_flag;
        logic       aborted_flag;
        logic       header_seen_flag;
        logic       reception_finished_flag;
        logic       ack_waived_flag;
        logic       transmit_finished_flag;
        logic [2:0] matched_sync_index;
        logic [7:0] tx_data;
        logic       tx_valid;
    } pkr_regs_t;

    pkr_regs_t r;
    pkr_regs_t next_r;
    logic [39:0] packet_report;
    logic        chirp_type;
    logic [7:0]  status_byte;
    logic [7:0]  error_byte;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] pkr_reply_byte(input logic [7:0]  opc,
                                                   input logic [2:0]  k,
                                                   input logic [39:0] snap,
                                                   input logic [7:0]  live);
        logic [7:0] b;
        b = PKR_FILL_BYTE;
        if (opc == PKR_OPC_READ_PACKET_REPORT && k < PKR_REPORT_BYTES) begin
            b = snap[{k, 3'h0} +: 8];
        end else if (opc == PKR_OPC_READ_LIVE_POWER && k == 3'h0) begin
            b = live;
        end
        return b;
    endfunction : pkr_reply_byte

    function automatic logic [7:0] pkr_uart_length(input logic [7:0] opc);
        logic [7:0] n;
        n = PKR_RST_BYTE;
        if (opc == PKR_OPC_READ_PACKET_REPORT) begin
            n = PKR_LEN_PACKET_REPORT;
        end else if (opc == PKR_OPC_READ_LIVE_POWER) begin
            n = PKR_LEN_LIVE_POWER;
        end
        return n;
    endfunction : pkr_uart_length

    // ------------------------------------------------------------
    // decoders
    // ------------------------------------------------------------
    // only one-hot codes name an address; anything else reads as none, and as a miss when sync detection is enabled
    function automatic logic pkr_sync_code_ok(input logic [2:0] code);
        return (code == PKR_SYNC_1) || (code == PKR_SYNC_2) || (code == PKR_SYNC_3);
    endfunction : pkr_sync_code_ok

    // a length byte is only good for a known opcode and its exact count
    function automatic logic pkr_length_ok(input logic [7:0] opc,
                                           input logic [7:0] len);
        logic ok;
        ok = 1'b0;
        if (pkr_uart_length(opc) != PKR_RST_BYTE) begin
            ok = (len == pkr_uart_length(opc));
        end
        return ok;
    endfunction : pkr_length_ok

    // saturates so a long run of fill bytes cannot wrap into the report
    function automatic logic [2:0] pkr_idx_step(input logic [2:0] k);
        logic [2:0] n;
        n = k;
        if (k != 3'h7) begin
            n = k + 3'h1;
        end
        return n;
    endfunction : pkr_idx_step

    // ------------------------------------------------------------
    // report assembly
    // ------------------------------------------------------------
    always_comb begin
        chirp_type = (config_in.pkt_type == PKR_PT_CHIRP) ||
                     (config_in.pkt_type == PKR_PT_RANGING);
        status_byte = PKR_RST_BYTE;
        status_byte[PKR_ST_ACK_WAIVED]  = r.ack_waived_flag;
        status_byte[PKR_ST_TX_FINISHED] = r.transmit_finished_flag;
        error_byte = PKR_RST_BYTE;
        error_byte[PKR_ER_SYNC_MISS]   = r.sync_miss_flag;
        error_byte[PKR_ER_OVERSIZE]    = r.oversize_length_flag;
        error_byte[PKR_ER_CHECKSUM]    = r.checksum_fail_flag;
        error_byte[PKR_ER_ABORTED]     = r.aborted_flag;
        error_byte[PKR_ER_HEADER_SEEN] = r.header_seen_flag;
        error_byte[PKR_ER_RX_FINISHED] = r.reception_finished_flag;
        error_byte[PKR_ER_BUSY]        = engine.busy;
        if (chirp_type) begin
            // upper bytes carry nothing for chirp types
            packet_report = {24'h000000, r.snr, r.sync_power_level};
        end else begin
            packet_report = {5'h00, r.matched_sync_index, status_byte, error_byte,
                             r.sync_power_level, PKR_FILL_BYTE};
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        if (r.tx_valid && tx_ready) begin
            next_r.tx_valid = 1'b0;
        end

        // ------------------------------------------------------------
        // packet flags
        // ------------------------------------------------------------
        // per-packet flags: set wins over the packet-start clear
        if (engine.packet_start) begin
            next_r.sync_miss_flag          = 1'b0;
            next_r.oversize_length_flag    = 1'b0;
            next_r.checksum_fail_flag      = 1'b0;
            next_r.aborted_flag            = 1'b0;
            next_r.header_seen_flag        = 1'b0;
            next_r.reception_finished_flag = 1'b0;
            next_r.transmit_finished_flag  = 1'b0;
        end
        if (engine.sync_seen) begin
            next_r.sync_power_level   = power_level;
            next_r.matched_sync_index = PKR_SYNC_NONE;
            if (pkr_sync_code_ok(engine.sync_index)) begin
                next_r.matched_sync_index = engine.sync_index;
            end else if (config_in.sync_detect_enable) begin
                next_r.sync_miss_flag = 1'b1;
            end
        end
        if (engine.oversize_length && config_in.dynamic_length) begin
            next_r.oversize_length_flag = 1'b1;
        end
        if (engine.checksum_fail && config_in.checksum_enable) begin
            next_r.checksum_fail_flag = 1'b1;
        end
        if (engine.aborted) begin
            next_r.aborted_flag = 1'b1;
        end
        if (engine.header_seen && config_in.dynamic_length) begin
            next_r.header_seen_flag = 1'b1;
        end
        if (engine.reception_finished) begin
            next_r.reception_finished_flag = 1'b1;
            next_r.ack_waived_flag = config_in.dynamic_length & engine.ack_field;
        end
        if (engine.transmit_finished) begin
            next_r.transmit_finished_flag = 1'b1;
        end

        // ------------------------------------------------------------
        // measurements
        // ------------------------------------------------------------
        // snr ignored outside chirp types so a stray estimate cannot leak
        if (engine.snr_valid && chirp_type) begin
            next_r.snr = engine.snr;
        end
        // chirp refresh only per symbol, others track every cycle
        if (!chirp_type || engine.symbol_tick) begin
            next_r.live_power_level = power_level;
        end

        // ------------------------------------------------------------
        // command parser
        // ------------------------------------------------------------
        // spi answers one byte per host byte; uart waits for the length
        unique case (r.st)
            PKR_S_IDLE: begin
            end
            PKR_S_OPCODE: begin
                if (rx_valid) begin
                    next_r.opcode = rx_byte;
                    next_r.snap   = packet_report; // frozen for the whole reply
                    next_r.idx    = 3'h1;
                    next_r.st     = PKR_S_ARGS;
                    if (!link_is_uart) begin
                        next_r.tx_data  = chip_status;
                        next_r.tx_valid = 1'b1;
                    end
                end
            end
            PKR_S_ARGS: begin
                if (rx_valid) begin
                    if (link_is_uart) begin
                        // wrong length byte: command dropped silently
                        if (pkr_length_ok(r.opcode, rx_byte)) begin
                            next_r.st   = PKR_S_REPLY;
                            next_r.idx  = 3'h0;
                            next_r.left = rx_byte[2:0];
                        end else begin
                            next_r.st = PKR_S_IDLE;
                        end
                    end else begin
                        next_r.idx = pkr_idx_step(r.idx);
                        next_r.tx_valid = 1'b1;
                        next_r.tx_data  = pkr_reply_byte(r.opcode,
                                                         r.idx - 3'h1,
                                                         r.snap, r.live_power_level);
                    end
                end
            end
            PKR_S_REPLY: begin
                // a stalled byte stays put until the link takes it
                if (!r.tx_valid || tx_ready) begin
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data  = pkr_reply_byte(r.opcode, r.idx,
                                                     r.snap, r.live_power_level);
                    next_r.idx  = pkr_idx_step(r.idx);
                    next_r.left = r.left - 3'h1;
                    if (r.left == 3'h1) begin
                        next_r.st = PKR_S_IDLE;
                    end
                end
            end
        endcase

        // ------------------------------------------------------------
        // frame restart
        // ------------------------------------------------------------
        // uart has no status slots; its reply waits for the length byte
        if (frame_start) begin
            next_r.st = PKR_S_OPCODE;
            if (!link_is_uart) begin
                next_r.tx_data  = chip_status;
                next_r.tx_valid = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // both straight from flops, nothing after the register
    assign tx_valid = r.tx_valid;
    assign tx_byte  = r.tx_data;

endmodule : pkr_packet_status_readout

// >>> pkr_host_model.sv
`timescale 1ns/1ps
// ----
// host side of the command link
// ----
module pkr_host (
    input  wire logic       clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            frame_start,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            tx_ready
);
    logic       slow = 1'b0;
    logic [7:0] got[$];
    initial begin
        frame_start = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h5a;
        tx_ready = 1'b1;
    end
    // stall only on uart, spi overwrites an untaken byte
    always @(posedge clk) begin
        // spi shifts the loaded byte out with each host byte; uart waits for ready
        if (slow ? (tx_valid && tx_ready) : (rx_valid && tx_valid)) got.push_back(tx_byte);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    // opcode, then length or first nop, then more nops
    task automatic send(input logic [7:0] op, input logic [7:0] arg, input int nops);
        got.delete();
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        rx_valid <= 1'b1;
        rx_byte <= op;
        @(posedge clk);
        rx_byte <= arg;
        repeat (nops) begin
            @(posedge clk);
            rx_byte <= 8'h00;
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~rx_byte;
        repeat (16) @(posedge clk);
    endtask : send
endmodule : pkr_host

// >>> pkr_packet_status_readout_monitor.sv
`timescale 1ns/1ps
module pkr_mon (
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 link_is_uart,
    input wire logic                 frame_start,
    input wire logic                 rx_valid,
    input wire logic [7:0]           rx_byte,
    input wire logic                 tx_valid,
    input wire logic                 tx_ready,
    input wire logic [7:0]           tx_byte,
    input wire logic [7:0]           chip_status,
    input wire logic [7:0]           power_level,
    input wire pkr_pkg::pkr_config_t config_in
);
    import pkr_pkg::*;
    logic plain;
    assign plain = config_in.pkt_type inside {PKR_PT_GFSK, PKR_PT_BLE};
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    spi_first_status_a: assert property (
        !link_is_uart && frame_start |=> tx_valid && tx_byte == $past(chip_status))
        else $error("first status slot wrong");
    spi_second_status_a: assert property (
        !link_is_uart && frame_start ##1 rx_valid
        |=> tx_valid && tx_byte == $past(chip_status)) else $error("second status slot wrong");
    uart_no_status_a: assert property (
        link_is_uart && frame_start && !tx_valid |=> !tx_valid [*2])
        else $error("uart sent a status byte");
    uart_hold_a: assert property (
        link_is_uart && tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("uart byte dropped before taken");
    uart_live_a: assert property (
        link_is_uart && plain && frame_start ##1 (rx_valid && rx_byte == PKR_OPC_READ_LIVE_POWER)
        ##1 (rx_valid && rx_byte == PKR_LEN_LIVE_POWER)
        |-> ##2 tx_valid && tx_byte == $past(power_level, 2))
        else $error("uart live power reply wrong");
    uart_bad_len_a: assert property (
        link_is_uart && frame_start && !tx_valid
        ##1 (rx_valid && rx_byte == PKR_OPC_READ_PACKET_REPORT)
        ##1 (rx_valid && rx_byte != PKR_LEN_PACKET_REPORT) |=> !tx_valid [*4])
        else $error("reply to bad length");
    report_reserved_a: assert property (
        link_is_uart && plain && frame_start ##1 (rx_valid && rx_byte == PKR_OPC_READ_PACKET_REPORT)
        ##1 (rx_valid && rx_byte == PKR_LEN_PACKET_REPORT) |-> ##2 tx_valid && tx_byte == 8'h00)
        else $error("reserved report byte not zero");
    spi_fill_a: assert property (
        !link_is_uart && frame_start ##1 (rx_valid && rx_byte == 8'h17) ##1 rx_valid
        |=> tx_valid && tx_byte == 8'h00) else $error("unknown opcode not filled");
endmodule : pkr_mon
bind pkr_packet_status_readout pkr_mon pkr_mon_i (.clk(clk), .rst(rst),
    .link_is_uart(link_is_uart), .frame_start(frame_start), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
    .chip_status(chip_status), .power_level(power_level), .config_in(config_in));

// >>> pkr_packet_status_readout_test.sv
`timescale 1ns/1ps
module pkr_packet_status_readout_test;
    import pkr_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        link_is_uart = 1'b0;
    logic [7:0]  chip_status = 8'ha5;
    logic [7:0]  power_level = 8'h00;
    pkr_engine_t engine = '0;
    pkr_config_t config_in = '0;
    logic        frame_start, rx_valid, tx_ready, tx_valid;
    logic [7:0]  rx_byte, tx_byte;
    int          miscompares = 0;
    int          total_checks = 0;
    int          t;
    always #5 clk = ~clk;
    pkr_packet_status_readout pkr_packet_status_readout_i (.clk(clk), .rst(rst),
        .link_is_uart(link_is_uart), .frame_start(frame_start), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte),
        .chip_status(chip_status), .power_level(power_level), .engine(engine),
        .config_in(config_in));
    pkr_host pkr_host_i (.clk(clk), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .frame_start(frame_start), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        total_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, want);
        end
    endtask : check
    // uart replies are stalled by the host to exercise holding
    task automatic ask(input logic u, input logic [7:0] op, input logic [7:0] want[$]);
        logic live;
        live = (op == PKR_OPC_READ_LIVE_POWER);
        link_is_uart <= u;
        pkr_host_i.slow <= u;
        if (u) pkr_host_i.send(op, live ? PKR_LEN_LIVE_POWER : PKR_LEN_PACKET_REPORT, 0);
        else pkr_host_i.send(op, 8'h00, live ? 1 : 5);
        check(8'(pkr_host_i.got.size()), 8'(want.size()));
        foreach (want[i]) check(pkr_host_i.got[i], want[i]);
    endtask : ask
    task automatic pulse(input pkr_engine_t ev);
        engine <= ev;
        @(posedge clk);
        engine <= '{busy: ev.busy, ack_field: ev.ack_field, default: '0};
        @(posedge clk);
    endtask : pulse
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        config_in <= '{PKR_PT_GFSK, 1'b1, 1'b1, 1'b1};
        power_level <= 8'h50;
        pulse('{packet_start: 1'b1, busy: 1'b1, default: '0});
        pulse('{sync_seen: 1'b1, sync_index: PKR_SYNC_2, header_seen: 1'b1, busy: 1'b1, default: '0});
        power_level <= 8'h3c;
        pulse('{reception_finished: 1'b1, oversize_length: 1'b1, checksum_fail: 1'b1,
                ack_field: 1'b1, busy: 1'b1, default: '0});
        ask(0, 8'h1d, {8'ha5, 8'ha5, 8'h00, 8'h50, 8'h37, 8'h20, 8'h02});
        ask(1, 8'h1d, {8'h00, 8'h50, 8'h37, 8'h20, 8'h02});
        ask(1, 8'h1f, {8'h3c});
        ask(0, 8'h1f, {8'ha5, 8'ha5, 8'h3c});
        $display("test 1 done");
        link_is_uart <= 1'b1;
        pkr_host_i.slow <= 1'b1;
        pkr_host_i.send(8'h1d, 8'h04, 0);
        check(8'(pkr_host_i.got.size()), 8'h00);
        ask(0, 8'h17, {8'ha5, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        $display("test 2 done");
        config_in <= '{PKR_PT_BLE, 1'b0, 1'b1, 1'b1};
        power_level <= 8'h44;
        pulse('{packet_start: 1'b1, default: '0});
        pulse('{sync_seen: 1'b1, sync_index: PKR_SYNC_NONE, aborted: 1'b1, transmit_finished: 1'b1,
                header_seen: 1'b1, oversize_length: 1'b1, default: '0});
        ask(0, 8'h1d, {8'ha5, 8'ha5, 8'h00, 8'h44, 8'h48, 8'h21, 8'h00});
        $display("test 3 done");
        config_in <= '{PKR_PT_CHIRP, 1'b1, 1'b1, 1'b1};
        power_level <= 8'h62;
        pulse('{packet_start: 1'b1, default: '0});
        pulse('{sync_seen: 1'b1, sync_index: PKR_SYNC_1, snr_valid: 1'b1, snr: 8'hf4, default: '0});
        ask(0, 8'h1d, {8'ha5, 8'ha5, 8'h62, 8'hf4, 8'h00, 8'h00, 8'h00});
        config_in <= '{PKR_PT_GFSK, 1'b1, 1'b1, 1'b1};
        pulse('{snr_valid: 1'b1, snr: 8'h08, default: '0});
        config_in <= '{PKR_PT_RANGING, 1'b1, 1'b1, 1'b1};
        ask(0, 8'h1d, {8'ha5, 8'ha5, 8'h62, 8'hf4, 8'h00, 8'h00, 8'h00});
        $display("test 4 done");
        for (t = 0; t < 4; t++) begin
            config_in <= '{pkr_pkt_type_t'(t), 1'b1, 1'b1, 1'b1};
            power_level <= 8'h20 + 8'(t);
            pulse('{symbol_tick: 1'b1, default: '0});
            power_level <= 8'h7f;
            repeat (2) @(posedge clk);
            ask(0, 8'h1f, {8'ha5, 8'ha5, (t > 1) ? 8'h20 + 8'(t) : 8'h7f});
        end
        $display("test 5 done");
        results();
    end
    initial begin
        #100us;
        miscompares++;
        results();
    end
endmodule : pkr_packet_status_readout_test
